/* common/scc_cfg.svh */
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// register byte offsets
`define SCC_CONFIG_OFFSET   8'h00
`define SCC_STATUS_OFFSET   8'h04

// config field positions
`define SCC_RC_EN_BIT       0
`define SCC_XTAL_EN_BIT     1
`define SCC_BYPASS_BIT      2
`define SCC_SEL_BIT         3
`define SCC_CONFIG_WIDTH    4

// status field positions
`define SCC_ACTIVE_SEL_BIT  0
`define SCC_BUSY_BIT        1

`define SCC_CONFIG_RESET    4'h1

// source change settles within this many slow clock cycles
`define SCC_RESYNC_SLOW_CYCLES 5
// rising edges of the new source seen before it drives the output
`define SCC_NEW_EDGES       2'h2

`define SCC_RESP_OKAY       2'h0
`define SCC_RESP_SLVERR     2'h2

`endif

/* common/scc_pkg.sv */
package scc_pkg;

  typedef enum logic [1:0] {
    SCC_ST_IDLE   = 2'b00,
    SCC_ST_DRAIN  = 2'b01,
    SCC_ST_SETTLE = 2'b10
  } scc_state_type;

  typedef struct packed {
    logic xtal_bypass;
    logic xtal_osc_enable;
    logic rc_osc_enable;
  } scc_osc_ctrl_type;

  typedef struct packed {
    logic switch_busy;
    logic active_select;
  } scc_status_type;

endpackage : scc_pkg

/* design/scc_sync.sv */
`timescale 1ns/100ps
module scc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds only the second flop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : scc_sync

/* design/scc_slow_clock_ctrl.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "scc_cfg.svh"

// Notes on behaviour
// - bit 0 enables RC oscillator
// - bit 1 enables crystal oscillator
// - bit 2 passes external clock from input pin
// - bit 3 selects RC or crystal path
// - reset value reads 0x0000_0001
// - contents kept while backup supply present
// - selector change completes within five slow cycles
module scc_slow_clock_ctrl (
  // clock and backup-domain reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // axi4-lite write address
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // oscillator clocks and external pin
  input  wire logic                     rc_osc_clk,
  input  wire logic                     xtal_osc_clk,
  input  wire logic                     slow_xtal_input,
  // oscillator controls, status and selected slow clock
  output scc_pkg::scc_osc_ctrl_type     osc_ctrl,
  output scc_pkg::scc_status_type       status,
  output logic                          slow_clock
);
  import scc_pkg::*;

  logic [`SCC_CONFIG_WIDTH-1:0] config_bits;
  logic                         aw_held;
  logic                         w_held;
  logic [7:0]                   aw_addr;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         do_write;
  logic [2:0]                   clk_sync;
  logic                         rc_level;
  logic                         xtal_level;
  logic                         pin_level;
  logic                         xtal_path;
  logic                         old_level;
  logic                         new_level;
  logic                         new_level_d;
  logic                         active_select;
  logic                         target_select;
  logic [1:0]                   edge_count;
  scc_state_type                state;
  logic [31:0]                  next_rdata;
  logic [1:0]                   next_rresp;

  // register write path: address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SCC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr[7:2] == 6'(`SCC_CONFIG_OFFSET >> 2)) begin
        s_axi_bresp <= `SCC_RESP_OKAY;
      end else if (aw_addr[7:2] == 6'(`SCC_STATUS_OFFSET >> 2)) begin
        s_axi_bresp <= `SCC_RESP_OKAY;
      end else begin
        s_axi_bresp <= `SCC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // rst_n is the backup-domain power-on reset only; main-domain resets
  // must not reach this register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      config_bits <= `SCC_CONFIG_RESET;
    end else if (do_write && w_strb[0] &&
                 aw_addr[7:2] == 6'(`SCC_CONFIG_OFFSET >> 2)) begin
      config_bits <= w_data[`SCC_CONFIG_WIDTH-1:0];
    end
  end

  assign osc_ctrl.rc_osc_enable   = config_bits[`SCC_RC_EN_BIT];
  assign osc_ctrl.xtal_osc_enable = config_bits[`SCC_XTAL_EN_BIT];
  assign osc_ctrl.xtal_bypass     = config_bits[`SCC_BYPASS_BIT];

  // register read path
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = `SCC_RESP_OKAY;
    if (s_axi_araddr[7:2] == 6'(`SCC_CONFIG_OFFSET >> 2)) begin
      next_rdata[`SCC_CONFIG_WIDTH-1:0] = config_bits;
    end else if (s_axi_araddr[7:2] == 6'(`SCC_STATUS_OFFSET >> 2)) begin
      next_rdata[`SCC_ACTIVE_SEL_BIT] = status.active_select;
      next_rdata[`SCC_BUSY_BIT]       = status.switch_busy;
    end else begin
      next_rresp = `SCC_RESP_SLVERR;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SCC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // oscillator outputs and the pin are asynchronous to ref_clk
  scc_sync #(
    .WIDTH (3)
  ) u_clk_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({slow_xtal_input, xtal_osc_clk, rc_osc_clk}),
    .sync_out (clk_sync)
  );

  assign rc_level   = clk_sync[0];
  assign xtal_level = clk_sync[1];
  assign pin_level  = clk_sync[2];
  // bypass replaces the crystal with the external pin clock
  assign xtal_path  = osc_ctrl.xtal_bypass ? pin_level : xtal_level;

  always_comb begin
    old_level = active_select ? xtal_path : rc_level;
    new_level = target_select ? xtal_path : rc_level;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      new_level_d <= 1'b0;
    end else begin
      new_level_d <= new_level;
    end
  end

  // source change: output forced low as it starts, cutting short any high phase of the old source; wait till it is low, then hand
  // over on a low phase of the new one after two of its rising edges;
  // worst case stays under the five slow cycles software waits
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state         <= SCC_ST_IDLE;
      active_select <= 1'b0;
      target_select <= 1'b0;
      edge_count    <= 2'h0;
    end else begin
      case (state)
        SCC_ST_IDLE: begin
          if (config_bits[`SCC_SEL_BIT] != active_select) begin
            target_select <= config_bits[`SCC_SEL_BIT];
            edge_count    <= 2'h0;
            state         <= SCC_ST_DRAIN;
          end
        end
        SCC_ST_DRAIN: begin
          if (!old_level) begin
            state <= SCC_ST_SETTLE;
          end
        end
        SCC_ST_SETTLE: begin
          if (new_level && !new_level_d && edge_count != `SCC_NEW_EDGES) begin
            edge_count <= edge_count + 2'h1;
          end else if (edge_count == `SCC_NEW_EDGES && !new_level) begin
            active_select <= target_select;
            state         <= SCC_ST_IDLE;
          end
        end
        default: begin
          state <= SCC_ST_IDLE;
        end
      endcase
    end
  end

  // output held low while a change is in progress
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slow_clock <= 1'b0;
    end else if (state == SCC_ST_IDLE) begin
      slow_clock <= old_level;
    end else begin
      slow_clock <= 1'b0;
    end
  end

  // old oscillator may be stopped by software once busy clears
  assign status.active_select = active_select;
  assign status.switch_busy   = (state != SCC_ST_IDLE);

endmodule : scc_slow_clock_ctrl

/* tb/scc_slow_clock_chk.sv */
`timescale 1ns/100ps
module scc_chk (
  // clock and reset
  input wire logic                      ref_clk,
  input wire logic                      rst_n,
  // bus answers
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  // oscillators and outputs
  input wire logic                      rc_osc_clk,
  input wire logic                      xtal_osc_clk,
  input wire logic                      slow_xtal_input,
  input wire scc_pkg::scc_osc_ctrl_type osc_ctrl,
  input wire scc_pkg::scc_status_type   status,
  input wire logic                      slow_clock
);
  import scc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rst; $rose(rst_n) |-> osc_ctrl == 3'h1; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_keep; !$stable(osc_ctrl) |-> $rose(s_axi_bvalid); endproperty
  a_keep: assert property (p_keep) else $error("control moved");
  property p_rsv; s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_bst; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bst: assert property (p_bst) else $error("write answer dropped");
  property p_rst_d;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rst_d: assert property (p_rst_d) else $error("read answer moved");
  // the slowest source bounds the switch, plus synchroniser latency
  property p_busy;
    $rose(status.switch_busy) |-> ##[1:130] !status.switch_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("switch too long");
  // output rises a few ref_clk cycles after its source, well inside the
  // high phase, so the raw source must still be high there
  property p_rc;
    $rose(slow_clock) && !status.switch_busy && !status.active_select
      |-> rc_osc_clk;
  endproperty
  a_rc: assert property (p_rc) else $error("not on rc");
  property p_xt;
    $rose(slow_clock) && !status.switch_busy && status.active_select &&
      !osc_ctrl.xtal_bypass |-> xtal_osc_clk;
  endproperty
  a_xt: assert property (p_xt) else $error("not on xtal");
  property p_byp;
    $rose(slow_clock) && !status.switch_busy && status.active_select &&
      osc_ctrl.xtal_bypass |-> slow_xtal_input;
  endproperty
  a_byp: assert property (p_byp) else $error("not on pin");
  c_sw: cover property ($rose(status.switch_busy));
  c_byp: cover property (slow_clock && osc_ctrl.xtal_bypass);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule : scc_chk

bind scc_slow_clock_ctrl scc_chk i_scc_chk (
  .ref_clk, .rst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .rc_osc_clk, .xtal_osc_clk,
  .slow_xtal_input, .osc_ctrl, .status, .slow_clock);

/* tb/scc_slow_clock_ctrl_bench.sv */
`timescale 1ns/100ps
`include "scc_cfg.svh"
module scc_slow_clock_ctrl_bench;
  import scc_pkg::*;
  logic ref_clk = 1'h0, rst_n = 1'h0, rc = 1'h0, xt = 1'h0, pin = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, slow_clock;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  scc_osc_ctrl_type osc_ctrl;
  scc_status_type status;
  int fails = 0, n_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  // unrelated periods, so a wrong source shows up as a misplaced edge
  always #50 rc = ~rc;
  always #55 xt = ~xt;
  always #60 pin = ~pin;
  scc_slow_clock_ctrl i_scc_slow_clock_ctrl (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rc_osc_clk(rc), .xtal_osc_clk(xt),
    .slow_xtal_input(pin), .osc_ctrl, .status, .slow_clock);
  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : cmp
  task wr(input logic [31:0] d, input logic [7:0] a = `SCC_CONFIG_OFFSET,
          input logic [1:0] r = `SCC_RESP_OKAY);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // bready stands from the start; only the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    cmp(32'(s_axi_bresp), 32'(r));
  endtask : wr
  task rd(input logic [31:0] d, input logic [7:0] a = `SCC_CONFIG_OFFSET,
          input logic [1:0] r = `SCC_RESP_OKAY);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    cmp(s_axi_rdata, d);
    cmp(32'(s_axi_rresp), 32'(r));
  endtask : rd
  task oc(input logic [2:0] e);
    cmp(32'(osc_ctrl), 32'(e));
  endtask : oc
  // five periods of the 120 ns pin clock, the slowest source; margin over the crystal and RC clocks, none over the pin
  task settle(input logic [31:0] e);
    repeat (120) @(posedge ref_clk);
    rd(e, `SCC_STATUS_OFFSET);
  endtask : settle
  task summarize;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    #20000;
    fails++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(32'h1);
    oc(3'h1);
    $display("test reset done");
    wr(32'h3);
    oc(3'h3);
    wr(32'hB);
    rd(32'h2, `SCC_STATUS_OFFSET);
    cmp(32'(slow_clock), 32'h0);
    settle(32'h1);
    wr(32'hFFFF_FFFA);
    rd(32'hA);
    oc(3'h2);
    wr(32'hB);
    wr(32'h3);
    settle(32'h0);
    wr(32'h1);
    oc(3'h1);
    $display("test switching done");
    wr(32'h7);
    wr(32'h5);
    oc(3'h5);
    wr(32'hD);
    settle(32'h1);
    wr(32'hC);
    oc(3'h4);
    $display("test bypass done");
    s_axi_wstrb <= 4'h0;
    wr(32'h1);
    s_axi_wstrb <= 4'hF;
    wr(32'h1, 8'h10, `SCC_RESP_SLVERR);
    rd(32'h0, 8'h10, `SCC_RESP_SLVERR);
    wr(32'h3, `SCC_STATUS_OFFSET);
    rd(32'hC);
    rst_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(32'h1);
    $display("test access done");
    summarize;
  end
endmodule : scc_slow_clock_ctrl_bench
